// ==== hdl/pptx_top.sv ====
// Transmit PDO producer of a linear position sensor with APB registers.
// Notes on behaviour
// RULE_01: transmission type selects sync or async mode.
// RULE_02: sync mode when operational and type 0..240.
// RULE_03: send one PDO every n sync messages.
// RULE_04: master sends sync, id 0x080, no data.
// RULE_05: sync recognised by programmable identifier.
// RULE_06: async mode when operational, type 254/255.
// RULE_07: async sends on event timer expiry, ms.
// RULE_08: PDO identifier is 0x180 plus node id.
// RULE_09: bytes: position 0-3, velocity 4-5, status 6.
// RULE_10: mapping readable from mapping register.
// RULE_11: measuring step readable from step register.
// RULE_12: default frame is 103 to 126 bits.
// RULE_13: cam switches when position crosses limit.
// RULE_14: cam enable, 8 bit, reset zero.
// RULE_15: cam polarity, 8 bit, reset zero.
// RULE_16: four signed 32-bit cam limits, reset zero.
// RULE_17: restart counters entering operational; else silent.
// RULE_18: types 241-253 silent; zero means every sync.
module pptx_top
   import pptx_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic reset,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Received frame strobe from the CAN controller.
   input wire logic rx_valid,
   input wire logic [10:0] rx_id,
   input wire logic [3:0] rx_dlc,
   // Network state and measurement.
   input wire logic nmt_operational,
   input wire logic [31:0] position,
   input wire logic [15:0] velocity,
   input wire logic [7:0] status,
   // Transmit request to the CAN controller.
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [10:0] tx_id,
   output logic [3:0] tx_dlc,
   output logic [63:0] tx_data,
   // Cam outputs.
   output logic [7:0] cam_state
);
   // Configuration registers.
   logic [7:0] ttype, next_ttype;
   logic [15:0] evtmr, next_evtmr;
   logic [10:0] sync_id, next_sync_id;
   logic [6:0] node_id, next_node_id;
   logic [31:0] step, next_step;
   logic [7:0] cam_en, next_cam_en;
   logic [7:0] cam_pol, next_cam_pol;
   logic [31:0] cam_pos [NCAMS];
   logic [31:0] next_cam_pos [NCAMS];
   logic [15:0] frames, next_frames;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr;
   // Operating state.
   logic op_q, next_op_q;
   logic [7:0] sync_cnt, next_sync_cnt;
   logic [MS_W-1:0] ms_div, next_ms_div;
   logic [15:0] ms_cnt, next_ms_cnt;
   logic next_tx_valid;
   logic [10:0] next_tx_id;
   logic [3:0] next_tx_dlc;
   logic [63:0] next_tx_data;
   logic sync_mode, async_mode, sync_seen, trigger, op_entry;
   logic [1:0] mode_bits;
   // Status word: cam outputs in bits 11:8, pending frame in bit 2,
   // async mode in bit 1 and sync mode in bit 0.

   // Transmission types 241 to 253 match neither mode, so the block
   // stays silent there; zero counts as a sync type like 1 to 240.
   function automatic logic [1:0] mode_of(input logic [7:0] tt);
      // Bit 0 sync, bit 1 async.
      mode_of = {(tt == TT_ASYNC_A) || (tt == TT_ASYNC_B),
                 tt <= TT_SYNC_MAX}; // RULE_01 RULE_18
   endfunction

   assign mode_bits = mode_of(ttype);
   assign sync_mode = nmt_operational && mode_bits[0]; // RULE_02
   assign async_mode = nmt_operational && mode_bits[1]; // RULE_06
   assign op_entry = nmt_operational && !op_q; // RULE_17
   // Only a zero-length frame on the programmed identifier counts as a
   // sync; a frame on the old default identifier is ignored once the
   // identifier has been reprogrammed.
   assign sync_seen = rx_valid && rx_id == sync_id &&
      rx_dlc == SYNC_DLC; // RULE_05

   // APB access: answers in the access cycle with no wait states.
   // Writes are stored at the setup edge, so a read right behind a
   // write already returns the new value. Unmapped offsets answer with
   // pslverr and leave every register as it was.
   always_comb begin
      next_ttype = ttype;
      next_evtmr = evtmr;
      next_sync_id = sync_id;
      next_node_id = node_id;
      next_step = step;
      next_cam_en = cam_en;
      next_cam_pol = cam_pol;
      next_cam_pos = cam_pos;
      next_prdata = 32'h0000_0000;
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      if (psel && !penable) begin
         next_pready = 1'b1;
         if (pwrite) begin
            unique case (paddr)
               REG_TTYPE: next_ttype = pwdata[7:0];
               REG_EVTMR: next_evtmr = pwdata[15:0];
               REG_SYNCID: next_sync_id = pwdata[10:0]; // RULE_05
               REG_NODEID: next_node_id = pwdata[6:0];
               REG_CAMEN: next_cam_en = pwdata[7:0]; // RULE_14
               REG_CAMPOL: next_cam_pol = pwdata[7:0]; // RULE_15
               REG_CAMPOS0: next_cam_pos[0] = pwdata; // RULE_16
               REG_CAMPOS0 + 8'h04: next_cam_pos[1] = pwdata;
               REG_CAMPOS0 + 8'h08: next_cam_pos[2] = pwdata;
               REG_CAMPOS0 + 8'h0C: next_cam_pos[3] = pwdata;
               // Read-only words take the write and drop it.
               REG_CTRL, REG_MAP, REG_MAP_VEL, REG_MAP_STS,
               REG_STEP, REG_STATUS, REG_FRAMES: ;
               default: next_pslverr = 1'b1;
            endcase
         end else begin
            unique case (paddr)
               REG_CTRL: next_prdata = {16'h0000, OBJ_TPDO_COMM};
               REG_TTYPE: next_prdata = {24'h000000, ttype};
               REG_EVTMR: next_prdata = {16'h0000, evtmr};
               REG_SYNCID: next_prdata = {21'h000000, sync_id};
               REG_NODEID: next_prdata = {25'h0000000, node_id};
               REG_MAP: next_prdata = MAP_POS; // RULE_10
               REG_MAP_VEL: next_prdata = MAP_VEL;
               REG_MAP_STS: next_prdata = MAP_STS;
               REG_STEP: next_prdata = step; // RULE_11
               REG_CAMEN: next_prdata = {24'h000000, cam_en};
               REG_CAMPOL: next_prdata = {24'h000000, cam_pol};
               REG_CAMPOS0: next_prdata = cam_pos[0];
               REG_CAMPOS0 + 8'h04: next_prdata = cam_pos[1];
               REG_CAMPOS0 + 8'h08: next_prdata = cam_pos[2];
               REG_CAMPOS0 + 8'h0C: next_prdata = cam_pos[3];
               REG_STATUS: next_prdata = {20'h00000, cam_state[3:0],
                  5'h00, tx_valid, async_mode, sync_mode};
               REG_FRAMES: next_prdata = {16'h0000, frames};
               default: next_pslverr = 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         ttype <= TTYPE_RST;
         evtmr <= EVTMR_RST;
         sync_id <= SYNC_ID_RST;
         node_id <= NODEID_RST;
         step <= STEP_RST;
         cam_en <= CAM_RST;
         cam_pol <= CAM_RST;
         for (int i = 0; i < NCAMS; i++) begin
            cam_pos[i] <= CAMPOS_RST;
         end
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         ttype <= next_ttype;
         evtmr <= next_evtmr;
         sync_id <= next_sync_id;
         node_id <= next_node_id;
         step <= next_step;
         cam_en <= next_cam_en;
         cam_pol <= next_cam_pol;
         cam_pos <= next_cam_pos;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // Sync counting, event timer and frame launch.
   // Leaving the operational state clears both counters, so the first
   // frame after re-entry always needs a full count of syncs or a full
   // timer period.
   always_comb begin
      next_op_q = nmt_operational;
      next_sync_cnt = sync_cnt;
      next_ms_div = ms_div;
      next_ms_cnt = ms_cnt;
      trigger = 1'b0;
      if (!nmt_operational || op_entry) begin
         next_sync_cnt = 8'h00; // RULE_17
         next_ms_div = '0;
         next_ms_cnt = 16'h0000;
      end else begin
         if (sync_mode && sync_seen) begin
            // Type 0 and type 1 both send on every sync.
            if (ttype == 8'h00 || sync_cnt + 8'h01 >= ttype) begin
               next_sync_cnt = 8'h00; // RULE_03 RULE_18
               trigger = 1'b1;
            end else begin
               next_sync_cnt = sync_cnt + 8'h01;
            end
         end
         // The millisecond divider only runs in async mode with a
         // non-zero period; a zero period holds both counters at rest.
         if (async_mode && evtmr != 16'h0000) begin
            if (ms_div == MS_LAST) begin
               next_ms_div = '0;
               if (ms_cnt + 16'h0001 >= evtmr) begin
                  next_ms_cnt = 16'h0000; // RULE_07
                  trigger = 1'b1;
               end else begin
                  next_ms_cnt = ms_cnt + 16'h0001;
               end
            end else begin
               next_ms_div = ms_div + MS_W'(1);
            end
         end else begin
            next_ms_div = '0;
            next_ms_cnt = 16'h0000;
         end
      end
      // A pending frame is dropped when the network leaves the
      // operational state, so no stale data goes out after re-entry.
      next_tx_valid = tx_valid && !tx_ready && nmt_operational;
      next_tx_id = tx_id;
      next_tx_dlc = tx_dlc;
      next_tx_data = tx_data;
      next_frames = frames;
      // A trigger that meets a pending frame, even one taken in this
      // very cycle, is lost; the next sync or period brings fresh data.
      if (trigger && !tx_valid) begin
         next_tx_valid = 1'b1;
         next_tx_id = PDO_BASE_ID + {4'h0, node_id}; // RULE_08
         // Seven data bytes make the 103 to 126 bit frame.
         next_tx_dlc = PDO_DLC; // RULE_12
         next_tx_data = {8'h00, status, velocity, position}; // RULE_09
         next_frames = frames + 16'h0001;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         op_q <= 1'b0;
         sync_cnt <= 8'h00;
         ms_div <= '0;
         ms_cnt <= 16'h0000;
         tx_valid <= 1'b0;
         tx_id <= 11'h000;
         tx_dlc <= 4'h0;
         tx_data <= 64'h0000_0000_0000_0000;
         frames <= 16'h0000;
      end else begin
         op_q <= next_op_q;
         sync_cnt <= next_sync_cnt;
         ms_div <= next_ms_div;
         ms_cnt <= next_ms_cnt;
         tx_valid <= next_tx_valid;
         tx_id <= next_tx_id;
         tx_dlc <= next_tx_dlc;
         tx_data <= next_tx_data;
         frames <= next_frames;
      end
   end

   // The cam compare sits in its own module; its registered outputs
   // line up in time with the other outputs of this block.
   pptx_cam u_cam (
      .mclk(mclk),
      .reset(reset),
      .cam_enable(cam_en),
      .cam_polarity(cam_pol),
      .cam_pos(cam_pos),
      .position(position),
      .cam_state(cam_state)
   );
endmodule

// ==== hdl/pptx_pkg.sv ====
// Package with register map, frame layout and timing constants.
package pptx_pkg;
   // Register byte offsets on the APB slave.
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_TTYPE = 8'h04;
   localparam logic [7:0] REG_EVTMR = 8'h08;
   localparam logic [7:0] REG_SYNCID = 8'h0C;
   localparam logic [7:0] REG_NODEID = 8'h10;
   localparam logic [7:0] REG_MAP = 8'h14;
   localparam logic [7:0] REG_STEP = 8'h18;
   localparam logic [7:0] REG_CAMEN = 8'h1C;
   localparam logic [7:0] REG_CAMPOL = 8'h20;
   localparam logic [7:0] REG_CAMPOS0 = 8'h24;
   localparam logic [7:0] REG_STATUS = 8'h34;
   localparam logic [7:0] REG_FRAMES = 8'h38;
   // Further mapping words, placed clear of the step and cam registers.
   localparam logic [7:0] REG_MAP_VEL = 8'h3C;
   localparam logic [7:0] REG_MAP_STS = 8'h40;
   // Object indices reflected in the register set.
   localparam logic [15:0] OBJ_TPDO_COMM = 16'h1800;
   localparam logic [15:0] OBJ_SYNC_ID = 16'h1005;
   localparam logic [15:0] OBJ_TPDO_MAP = 16'h1A00;
   localparam logic [15:0] OBJ_STEP = 16'h6005;
   localparam logic [15:0] OBJ_CAM_EN = 16'h6301;
   localparam logic [15:0] OBJ_CAM_POL = 16'h6302;
   localparam logic [15:0] OBJ_CAM_POS0 = 16'h6310;
   localparam logic [15:0] OBJ_CAM_POS3 = 16'h6313;
   // Reset values.
   localparam logic [10:0] SYNC_ID_RST = 11'h080;
   localparam logic [10:0] PDO_BASE_ID = 11'h180;
   localparam logic [7:0] TTYPE_RST = 8'hFF;
   localparam logic [15:0] EVTMR_RST = 16'h0064;
   localparam logic [6:0] NODEID_RST = 7'h01;
   localparam logic [31:0] STEP_RST = 32'h0000_0001;
   localparam logic [7:0] CAM_RST = 8'h00;
   localparam logic [31:0] CAMPOS_RST = 32'h0000_0000;
   // Transmission type limits.
   localparam logic [7:0] TT_SYNC_MAX = 8'hF0;
   localparam logic [7:0] TT_ASYNC_A = 8'hFE;
   localparam logic [7:0] TT_ASYNC_B = 8'hFF;
   // Frame layout.
   localparam logic [3:0] PDO_DLC = 4'h7;
   localparam logic [3:0] SYNC_DLC = 4'h0;
   localparam int FRAME_BITS_MIN = 103;
   localparam int FRAME_BITS_MAX = 126;
   // Mapping entries: index, sub-index, length in bits.
   localparam logic [31:0] MAP_POS = 32'h6004_0020;
   localparam logic [31:0] MAP_VEL = 32'h6030_0110;
   localparam logic [31:0] MAP_STS = 32'h6300_0108;
   // Timing.
   localparam int CLK_HZ = 20_000_000;
   localparam int MS_PER_S = 1000;
   localparam int TICK_MS = 1;
   localparam int MS_CYCLES = CLK_HZ / MS_PER_S * TICK_MS;
   localparam int MS_W = 15;
   localparam logic [MS_W-1:0] MS_LAST = MS_W'(MS_CYCLES - 1);
   localparam int NCAMS = 4;
endpackage

// ==== hdl/pptx_cam.sv ====
// Cam switch: compares position with four limits under enable and polarity.
module pptx_cam
   import pptx_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic reset,
   // Configuration.
   input wire logic [7:0] cam_enable,
   input wire logic [7:0] cam_polarity,
   input wire logic [31:0] cam_pos [NCAMS],
   // Position and result.
   input wire logic [31:0] position,
   output logic [7:0] cam_state
);
   logic [7:0] next_cam_state;

   always_comb begin
      next_cam_state = 8'h00;
      for (int i = 0; i < NCAMS; i++) begin
         // Active at or above the limit, inverted by polarity, gated by enable.
         next_cam_state[i] = cam_enable[i] &
            (($signed(position) >= $signed(cam_pos[i])) ^
             cam_polarity[i]); // RULE_13
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         cam_state <= 8'h00;
      end else begin
         cam_state <= next_cam_state;
      end
   end
endmodule

// ==== tb/pptx_top_assertions.sv ====
// Port checks of the position PDO transmitter.
module pptx_top_assertions
   import pptx_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic reset,
   // APB.
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   // Measurement and frames.
   input wire logic nmt_operational,
   input wire logic [31:0] position,
   input wire logic [15:0] velocity,
   input wire logic [7:0] status,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [10:0] tx_id,
   input wire logic [3:0] tx_dlc,
   input wire logic [63:0] tx_data,
   input wire logic [7:0] cam_state
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   chk_apb_answer:
      assert property (psel && !penable |=> pready)
      else $error("no answer in access phase");
   chk_apb_idle:
      assert property (!psel |=> !pready)
      else $error("answer without request");
   chk_frame_ident:
      assert property (tx_valid |-> tx_id[10:7] == 4'h3)
      else $error("frame identifier outside base range");
   chk_frame_length:
      assert property (tx_valid |-> tx_dlc == PDO_DLC)
      else $error("frame length wrong");
   chk_frame_payload:
      assert property ($rose(tx_valid) |-> tx_data[55:0] ==
         {$past(status), $past(velocity), $past(position)})
      else $error("payload layout wrong");
   chk_frame_hold:
      assert property (tx_valid && !tx_ready && nmt_operational
         |=> tx_valid && $stable(tx_data) && $stable(tx_id))
      else $error("frame request not held");
   chk_frame_release:
      assert property (tx_valid && tx_ready |=> !tx_valid)
      else $error("frame request kept after handshake");
   chk_silent_offline:
      assert property (!nmt_operational [*2] |-> !tx_valid)
      else $error("frame outside operational state");
   chk_rise_online:
      assert property ($rose(tx_valid) |-> $past(nmt_operational))
      else $error("frame started while not operational");
   chk_cam_upper:
      assert property (cam_state[7:4] == 4'h0)
      else $error("unused cam outputs active");
   cover property (tx_valid && tx_ready);
   cover property (tx_valid && !tx_ready ##1 tx_valid);
   cover property ($rose(cam_state[0]));
endmodule

bind pptx_top pptx_top_assertions chk_u (.mclk(mclk), .reset(reset),
   .psel(psel), .penable(penable), .pready(pready),
   .nmt_operational(nmt_operational), .position(position),
   .velocity(velocity), .status(status), .tx_valid(tx_valid),
   .tx_ready(tx_ready), .tx_id(tx_id), .tx_dlc(tx_dlc),
   .tx_data(tx_data), .cam_state(cam_state));

// ==== tb/pptx_master_model.sv ====
// Network master model: sync frames and transmit acknowledge.
module pptx_master_model (
   // Clock.
   input wire logic mclk,
   // Frame side.
   input wire logic tx_valid,
   input wire logic slow,
   output logic tx_ready = 1'b0,
   output logic rx_valid = 1'b0,
   output logic [10:0] rx_id = 11'h7FF,
   output logic [3:0] rx_dlc = 4'hF
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] wait_cnt = 3'h0;
   // A slow master stalls three cycles before taking the frame.
   always @(posedge mclk) begin
      wait_cnt <= (tx_valid && !tx_ready) ? wait_cnt + 3'h1 : 3'h0;
      tx_ready <= tx_valid && !tx_ready && (!slow || wait_cnt >= 3'h3);
   end
   // Released lines carry the inverse of the last frame.
   task automatic send(input logic [10:0] id, input logic [3:0] dlc);
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_id <= id;
      rx_dlc <= dlc;
      @(posedge mclk);
      rx_valid <= 1'b0;
      rx_id <= ~id;
      rx_dlc <= ~dlc;
   endtask
endmodule

// ==== tb/tb.sv ====
// Self-checking bench of the position PDO transmitter.
module tb;
   import pptx_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0, reset = 1'b1, slow = 1'b0, nmt_operational = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
   logic [7:0] paddr = 8'h00, status = 8'h00, cam_state;
   logic [31:0] pwdata = 32'h0, prdata, position = 32'h0;
   logic [15:0] velocity = 16'h0;
   logic rx_valid, tx_valid, tx_ready;
   logic [10:0] rx_id, tx_id;
   logic [3:0] rx_dlc, tx_dlc;
   logic [63:0] tx_data;
   logic [31:0] seed = 32'h6;
   logic [70:0] rq[$], fq[$];
   int err_count = 0, compares = 0;
   logic [8:0] plan [5] = '{9'h103, 9'h100, 9'h101, 9'h1F5, 9'h001};
   logic [33:0] cam_plan [5] = '{{2'h2, 32'h32}, {2'h0, 32'hFFFF_FF38},
      {2'h3, 32'hFFFF_FF38}, {2'h1, 32'h32}, {2'h2, 32'hFFFF_FF9C}};

   pptx_top dut_u (.mclk(mclk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_valid(rx_valid), .rx_id(rx_id), .rx_dlc(rx_dlc),
      .nmt_operational(nmt_operational), .position(position),
      .velocity(velocity), .status(status), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_id(tx_id), .tx_dlc(tx_dlc),
      .tx_data(tx_data), .cam_state(cam_state));
   pptx_master_model partner_u (.mclk(mclk), .tx_valid(tx_valid),
      .slow(slow), .tx_ready(tx_ready), .rx_valid(rx_valid),
      .rx_id(rx_id), .rx_dlc(rx_dlc));

   initial begin
      forever #25 mclk = ~mclk;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic void note(input logic [6:0] node);
      fq.push_back({PDO_BASE_ID + {4'h0, node}, PDO_DLC, status, velocity,
         position});
   endfunction

   task automatic check(input string what, input logic [70:0] exp,
      input logic [70:0] got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [32:0] exp);
      rq.push_back({38'h0, exp});
      apb(1'b0, a, xs());
   endtask

   task automatic meas();
      @(posedge mclk);
      position <= xs();
      velocity <= 16'(xs());
      status <= 8'(xs());
   endtask

   task automatic drain(input int n);
      repeat (n) if (fq.size() != 0) @(posedge mclk);
      repeat (4) @(posedge mclk);
      check("queue", 71'h0, 71'(fq.size()));
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   always @(posedge mclk) begin
      if (psel && penable && pready && !pwrite)
         check("read", rq.pop_front(), {38'h0, pslverr, prdata});
      if (tx_valid && tx_ready)
         check("frame", fq.size() != 0 ? fq.pop_front() : 71'h0,
            {tx_id, tx_dlc, tx_data[55:0]});
   end

   initial begin
      repeat (60000) @(posedge mclk);
      err_count++;
      $display("mismatch watchdog expected finish seen timeout");
      results();
   end

   initial begin
      int n;
      repeat (20) @(posedge mclk);
      reset <= 1'b0;
      rd(REG_TTYPE, {1'b0, 24'h0, TTYPE_RST});
      rd(REG_SYNCID, {1'b0, 21'h0, SYNC_ID_RST});
      rd(REG_CAMPOL, 33'h0);
      rd(REG_CAMPOS0 + 8'h0C, 33'h0);
      rd(REG_MAP, {1'b0, MAP_POS});
      rd(REG_MAP_STS, {1'b0, MAP_STS});
      rd(REG_STEP, {1'b0, STEP_RST});
      rd(REG_CAMEN, 33'h0);
      rd(8'hFC, {1'b1, 32'h0});
      $display("test registers done");
      apb(1'b1, REG_NODEID, 32'h0000_0005);
      apb(1'b1, REG_SYNCID, 32'h0000_0081);
      foreach (plan[k]) begin
         nmt_operational <= 1'b0;
         apb(1'b1, REG_TTYPE, {24'h0, plan[k][7:0]});
         nmt_operational <= plan[k][8];
         n = (plan[k][7:0] == 8'h00) ? 1 : int'(plan[k][7:0]);
         for (int i = 1; i <= 6; i++) begin
            meas();
            slow <= i[0];
            partner_u.send(SYNC_ID_RST, SYNC_DLC);
            partner_u.send(11'h081, 4'h1);
            partner_u.send(11'h081, SYNC_DLC);
            if (plan[k][8] && plan[k][7:0] <= TT_SYNC_MAX && i % n == 0)
               note(7'h05);
            drain(40);
         end
      end
      $display("test sync done");
      nmt_operational <= 1'b0;
      apb(1'b1, REG_TTYPE, 32'h0000_00FE);
      apb(1'b1, REG_EVTMR, 32'h0000_0001);
      meas();
      @(posedge mclk);
      nmt_operational <= 1'b1;
      note(7'h05);
      repeat (19900) @(posedge mclk);
      check("early", 71'h1, 71'(fq.size()));
      drain(2000);
      nmt_operational <= 1'b0;
      $display("test timer done");
      apb(1'b1, REG_CAMEN, 32'h0000_0001);
      apb(1'b1, REG_CAMPOS0, 32'hFFFF_FF9C);
      foreach (cam_plan[j]) begin
         apb(1'b1, REG_CAMPOL, {31'h0, cam_plan[j][32]});
         position <= cam_plan[j][31:0];
         repeat (4) @(posedge mclk);
         check("cam", {70'h0, cam_plan[j][33]}, {63'h0, cam_state});
      end
      $display("test cam done");
      results();
   end
endmodule
